// *** dv/host_model.sv ***
// Host controller model driving the register port
`timescale 1ns/1ps
`default_nettype none

module host_model
   import rx_ctrl_pkg::*;
(
   input wire logic i_clk,
   input wire logic [7:0] i_rdata,
   input wire logic i_rvalid,
   output rx_ctrl_pkg::reg_req_t o_req
);
   initial o_req = '0;

   // Idle bus shows inverted address and data, never a stale copy
   task automatic put(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(negedge i_clk);
      o_req = '{w, !w, a, d};
      @(negedge i_clk);
      o_req = '{1'b0, 1'b0, ~a, ~d};
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      put(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
      int n;
      put(1'b0, a, 8'h00);
      n = 0;
      while (i_rvalid !== 1'b1 && n < 4) begin
         @(negedge i_clk);
         n++;
      end
      ok = i_rvalid;
      d = i_rdata;
   endtask
endmodule
`default_nettype wire

// *** dv/rx_ctrl_monitor.sv ***
// Concurrent checks on the receive control block ports
`timescale 1ns/1ps
`default_nettype none

module rx_ctrl_monitor
   import rx_ctrl_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire rx_ctrl_pkg::reg_req_t i_reg,
   input wire logic i_tx_active,
   input wire logic i_rx_sof,
   input wire logic i_rx_bit,
   input wire logic i_rx_collision,
   input wire logic o_reg_rvalid,
   input wire rx_ctrl_pkg::mode_t o_mode,
   input wire logic o_rx_enable,
   input wire logic o_decoder_reset,
   input wire logic o_collision_event,
   input wire logic o_no_response_event
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);

   // ==========================================
   // Assertions
   a_coll_event: assert property (
      i_rx_bit && i_rx_collision && o_mode.valid && o_mode.protocol == PROT_PROX_A
      |=> o_collision_event) else $error("collision not flagged");
   a_coll_cause: assert property (
      o_collision_event |-> $past(i_rx_bit && i_rx_collision))
      else $error("collision flag without collided bit");
   a_tx_blanks: assert property (
      i_tx_active |=> o_decoder_reset) else $error("decoders live during transmit");
   a_blank_hold: assert property (
      $fell(i_tx_active) |-> o_decoder_reset) else $error("blanking lost at tx end");
   a_idle_invalid: assert property (
      !o_mode.valid |-> o_decoder_reset && !o_rx_enable)
      else $error("receive active on invalid code");
   a_valid_enables: assert property (
      o_mode.valid && $past(o_mode.valid) && !$past(i_sys_rst) |-> o_rx_enable)
      else $error("receive off on valid code");
   a_prox_a_mode: assert property (
      i_reg.wr && i_reg.addr == 8'h01 && i_reg.wdata[5:2] == 4'b0010
      |=> o_mode.op_mode == OP_READER && o_mode.protocol == PROT_PROX_A
      && o_mode.rate == $past(i_reg.wdata[1:0])) else $error("type A decode wrong");
   a_card_b_mode: assert property (
      i_reg.wr && i_reg.addr == 8'h01 && i_reg.wdata[5:0] == 6'h25
      |=> o_mode.op_mode == OP_CARD_EMU && o_mode.protocol == PROT_PROX_B)
      else $error("card B decode wrong");
   a_sof_quiets: assert property (
      i_rx_sof |=> !o_no_response_event [*3]) else $error("no-response after reply");

   // ==========================================
   // Coverage
   c_coll: cover property (o_collision_event);
   c_no_resp: cover property (o_no_response_event);
   c_card: cover property (o_mode.op_mode == OP_CARD_EMU);
   c_rvalid: cover property (o_reg_rvalid);
endmodule

bind rx_ctrl rx_ctrl_monitor rx_ctrl_monitor_inst (
   .i_clk(i_clk),
   .i_sys_rst(i_sys_rst),
   .i_reg(i_reg),
   .i_tx_active(i_tx_active),
   .i_rx_sof(i_rx_sof),
   .i_rx_bit(i_rx_bit),
   .i_rx_collision(i_rx_collision),
   .o_reg_rvalid(o_reg_rvalid),
   .o_mode(o_mode),
   .o_rx_enable(o_rx_enable),
   .o_decoder_reset(o_decoder_reset),
   .o_collision_event(o_collision_event),
   .o_no_response_event(o_no_response_event)
);
`default_nettype wire

// *** dv/rx_ctrl_tb_top.sv ***
// Self-checking bench for the receive control block
`timescale 1ns/1ps
`default_nettype none
`include "rx_ctrl_regs.svh"

module rx_ctrl_tb_top;
   import rx_ctrl_pkg::*;
   logic i_clk = 0, i_sys_rst = 1, i_cmd_valid = 0, i_tx_active = 0, i_slot_start = 0;
   logic i_rx_sof = 0, i_rx_active = 0, i_rx_frame_start = 0, i_rx_bit = 0;
   logic i_rx_collision = 0, i_osc_stable = 1;
   logic [7:0] i_cmd_code = 8'h00;
   rssi_levels_t i_rssi = '0;
   reg_req_t i_reg;
   logic [7:0] o_reg_rdata, o_chip_status_control;
   logic o_reg_rvalid, o_rx_enable, o_decoder_reset, o_collision_event, o_no_response_event;
   logic [5:0] o_irq_mask;
   mode_t o_mode;
   int fails = 0, samples_checked = 0, seed = 17029, cycles = 0, n, c, r;
   logic [11:0] e, k;
   logic [2:0] mm, ma;

   rx_ctrl rx_ctrl_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_reg(i_reg),
      .i_cmd_valid(i_cmd_valid), .i_cmd_code(i_cmd_code), .i_tx_active(i_tx_active),
      .i_slot_start(i_slot_start), .i_rx_sof(i_rx_sof), .i_rx_active(i_rx_active),
      .i_rx_frame_start(i_rx_frame_start), .i_rx_bit(i_rx_bit),
      .i_rx_collision(i_rx_collision), .i_rssi(i_rssi), .i_osc_stable(i_osc_stable),
      .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid), .o_mode(o_mode),
      .o_rx_enable(o_rx_enable), .o_decoder_reset(o_decoder_reset),
      .o_collision_event(o_collision_event), .o_no_response_event(o_no_response_event),
      .o_irq_mask(o_irq_mask), .o_chip_status_control(o_chip_status_control));
   host_model host_model_inst (.i_clk(i_clk), .i_rdata(o_reg_rdata),
      .i_rvalid(o_reg_rvalid), .o_req(i_reg));

   initial begin
      forever #12.5 i_clk = ~i_clk;
   end

   // ==========================================
   // Reference decode: expected mode and mask of meaningful fields
   function automatic void model(input logic [5:0] c, output logic [11:0] e,
                                 output logic [11:0] k);
      e = 12'h000;
      k = 12'h800;
      if (!c[5] && c[4:3] == 2'b00) begin
         e = {1'b1, OP_READER, PROT_VICINITY, 1'b0, c[1], c[2], c[0], 2'b00};
         k = 12'hffc;
      end else if (!c[5] && !c[4]) begin
         e = {1'b1, OP_READER, c[2] ? PROT_PROX_B : PROT_PROX_A, c[1:0], 4'h0};
         k = 12'hff0;
      end else if (!c[5] && c[1]) begin
         e = {1'b1, OP_READER, PROT_THIRD_PARTY, c[0], !c[0], 4'h0};
         k = 12'hff0;
      end else if (c[5] && !c[2] && c[1:0] != 2'b00) begin
         e = {1'b1, OP_PEER, PROT_PROX_A, 2'(c[1:0] - 2'd1), 2'b00, c[4], c[3]};
         k = 12'hff3;
      end else if (c[5] && c[2] && !c[1]) begin
         e = {1'b1, OP_CARD_EMU, c[0] ? PROT_PROX_B : PROT_PROX_A, 6'h00};
         k = 12'hfc0;
      end
   endfunction

   // ==========================================
   // Compare and stimulus tasks
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic chk_mode(input logic [11:0] got, input logic [11:0] ex,
                           input logic [11:0] km);
      chk(got & km, ex & km);
   endtask

   // Timer edges are loosely pinned, so allow two cycles either way
   task automatic chk_near(input int got, input int exp);
      chk(12'((got >= exp - 2 && got <= exp + 2) ? exp : got), 12'(exp));
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] v;
      logic ok;
      host_model_inst.rd(a, v, ok);
      chk(ok ? {4'h0, v} : 12'hfff, {4'h0, exp});
   endtask

   task automatic pulse(ref logic s);
      @(negedge i_clk) s = 1'b1;
      @(negedge i_clk) s = 1'b0;
   endtask

   task automatic wait_for(ref logic s, input logic lvl, input int lim);
      n = 0;
      while (s !== lvl && n < lim) begin
         @(negedge i_clk);
         n++;
      end
   endtask

   task automatic tx_burst;
      @(negedge i_clk) i_tx_active = 1'b1;
      repeat (4) @(negedge i_clk);
      i_tx_active = 1'b0;
   endtask

   task automatic coll(input logic [9:0] p, input logic ev);
      int i;
      pulse(i_rx_frame_start);
      for (i = 0; i <= p; i++) begin
         i_rx_bit = 1'b1;
         i_rx_collision = (i == p);
         @(negedge i_clk);
      end
      i_rx_bit = 1'b0;
      i_rx_collision = 1'b0;
      chk({11'h0, o_collision_event}, {11'h0, ev});
      if (ev) begin
         host_model_inst.wr(`REG_COLLISION_POSITION_LOW, ~p[7:0]);
         rd_chk(`REG_COLLISION_POSITION_LOW, p[7:0]);
         rd_chk(`REG_COLLISION_HIGH_AND_IRQ_MASK, {p[9:8], 6'h00});
      end
   endtask

   task automatic end_sim;
      if (fails == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         end_sim();
      end
   end

   // ==========================================
   // Main sequence
   initial begin
      repeat (8) @(negedge i_clk);
      i_sys_rst = 1'b0;
      model(6'h02, e, k);
      chk_mode(o_mode, e, k);
      rd_chk(`REG_PROTOCOL_SELECT, `RST_PROTOCOL_SELECT);
      rd_chk(`REG_RECEIVE_BLANK_TIME, `BLANK_PRESET_VICINITY);
      rd_chk(8'h05, 8'h00);
      for (c = 0; c < 64; c++) begin
         r = $random(seed);
         host_model_inst.wr(`REG_RECEIVE_BLANK_TIME, r[7:0]);
         host_model_inst.wr(`REG_NO_RESPONSE_WAIT_TIME, r[15:8]);
         host_model_inst.wr(`REG_PROTOCOL_SELECT, {r[17:16], 6'(c)});
         model(6'(c), e, k);
         chk_mode(o_mode, e, k);
         @(negedge i_clk);
         chk({11'h0, o_rx_enable}, {11'h0, e[11]});
         if (e[11]) begin
            rd_chk(`REG_RECEIVE_BLANK_TIME, (e[8:6] == PROT_VICINITY
               || e[8:6] == PROT_THIRD_PARTY) ? 8'h1f : 8'h0e);
            rd_chk(`REG_NO_RESPONSE_WAIT_TIME, `NO_RESP_PRESET_PEER);
         end
      end
      host_model_inst.wr(`REG_PROTOCOL_SELECT, 8'h08);
      foreach (e[i]) begin
         if (i < 4) begin
            host_model_inst.wr(`REG_RECEIVE_BLANK_TIME, 8'(i));
            tx_burst();
            wait_for(o_decoder_reset, 1'b0, 2000);
            chk_near(n, i * 378);
         end
      end
      host_model_inst.wr(`REG_NO_RESPONSE_WAIT_TIME, 8'h01);
      pulse(i_slot_start);
      wait_for(o_no_response_event, 1'b1, 4000);
      chk_near(n, 1511);
      host_model_inst.wr(`REG_NO_RESPONSE_WAIT_TIME, 8'h02);
      pulse(i_slot_start);
      repeat (200) @(negedge i_clk);
      pulse(i_rx_sof);
      wait_for(o_no_response_event, 1'b1, 3500);
      chk_near(n, 3500);
      coll(`COLL_ID_FIRST_BIT, 1'b1);
      coll(10'($random(seed)), 1'b1);
      coll(10'h3ff, 1'b1);
      host_model_inst.wr(`REG_PROTOCOL_SELECT, 8'h02);
      coll(10'h010, 1'b0);
      host_model_inst.wr(`REG_COLLISION_HIGH_AND_IRQ_MASK, 8'h15);
      rd_chk(`REG_COLLISION_HIGH_AND_IRQ_MASK, 8'hd5);
      chk({6'h00, o_irq_mask}, 12'h015);
      host_model_inst.wr(`REG_CHIP_STATUS_CONTROL, 8'h20);
      tx_burst();
      rd_chk(`REG_SIGNAL_LEVEL_OSC_STATUS, 8'h40);
      mm = 3'h0;
      ma = 3'h0;
      i_rx_active = 1'b1;
      repeat (3) begin
         @(negedge i_clk) i_rssi = 9'($random(seed));
         if (i_rssi.main > mm) mm = i_rssi.main;
         if (i_rssi.aux > ma) ma = i_rssi.aux;
      end
      @(negedge i_clk) i_rx_active = 1'b0;
      repeat (2) @(negedge i_clk);
      rd_chk(`REG_SIGNAL_LEVEL_OSC_STATUS, {2'b01, ma, mm});
      i_rssi = {6'h3f, 3'($random(seed))};
      i_cmd_code = `CMD_RSSI_MEASURE;
      pulse(i_cmd_valid);
      rd_chk(`REG_SIGNAL_LEVEL_OSC_STATUS, 8'h7f);
      host_model_inst.wr(`REG_CHIP_STATUS_CONTROL, 8'h22);
      chk({4'h0, o_chip_status_control}, 12'h022);
      pulse(i_cmd_valid);
      rd_chk(`REG_SIGNAL_LEVEL_OSC_STATUS, {5'b01000, i_rssi.ext});
      tx_burst();
      rd_chk(`REG_SIGNAL_LEVEL_OSC_STATUS, 8'h40);
      end_sim();
   end
endmodule
`default_nettype wire

// *** inc/rx_ctrl_pkg.sv ***
// Types shared by the receive control block and its bench
package rx_ctrl_pkg;

   // ==========================================
   // Operating modes and protocols
   typedef enum logic [1:0] {
      OP_READER,
      OP_PEER,
      OP_CARD_EMU
   } op_mode_t;

   typedef enum logic [2:0] {
      PROT_NONE,
      PROT_VICINITY,
      PROT_PROX_A,
      PROT_PROX_B,
      PROT_THIRD_PARTY
   } protocol_t;

   // Rate index: 0 = 106 kbps or vicinity low, 1 = 212 or vicinity high, 2 = 424, 3 = 848
   typedef struct packed {
      logic valid;
      op_mode_t op_mode;
      protocol_t protocol;
      logic [1:0] rate;
      logic dual_subcarrier;
      logic coding_256;
      logic initiator;
      logic active_comm;
   } mode_t;

   // ==========================================
   // Host register port
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic [2:0] main;
      logic [2:0] aux;
      logic [2:0] ext;
   } rssi_levels_t;

endpackage

// *** inc/rx_ctrl_regs.svh ***
// Register map, field positions, presets and timing constants of the receive control block
`ifndef RX_CTRL_REGS_SVH
`define RX_CTRL_REGS_SVH

// ==========================================
// Register offsets
`define REG_CHIP_STATUS_CONTROL 8'h00
`define REG_PROTOCOL_SELECT 8'h01
`define REG_NO_RESPONSE_WAIT_TIME 8'h07
`define REG_RECEIVE_BLANK_TIME 8'h08
`define REG_COLLISION_HIGH_AND_IRQ_MASK 8'h0d
`define REG_COLLISION_POSITION_LOW 8'h0e
`define REG_SIGNAL_LEVEL_OSC_STATUS 8'h0f

// ==========================================
// Reset values
`define RST_CHIP_STATUS_CONTROL 8'h00
`define RST_PROTOCOL_SELECT 8'h02
`define RST_IRQ_MASK 6'h00

// ==========================================
// Field positions
`define PSEL_PEER_BIT 5
`define PSEL_ROLE_BIT 4
`define PSEL_ACTIVE_BIT 3
`define PSEL_CARD_BIT 2
`define CSC_RSSI_EXT_BIT 1
`define CSC_TX_ON_BIT 5
`define SLS_OSC_BIT 6
`define COLL_HIGH_LSB 6
`define COLL_ID_FIRST_BIT 10'h010

// ==========================================
// Direct commands
`define CMD_RSSI_MEASURE 8'h18

// ==========================================
// Timing: unit times in picoseconds, clock in MHz
`define CLK_MHZ 40
`define BLANK_UNIT_PS 9440000
`define NO_RESP_UNIT_PS 37760000
`define PS_PER_US 1000000

// ==========================================
// Per-protocol timer presets (units of the timer)
`define BLANK_PRESET_VICINITY 8'h1f
`define BLANK_PRESET_PROX_A 8'h0e
`define BLANK_PRESET_PROX_B 8'h0e
`define BLANK_PRESET_THIRD 8'h1f
`define BLANK_PRESET_PEER 8'h0e
`define NO_RESP_PRESET_VICINITY 8'h0e
`define NO_RESP_PRESET_PROX_A 8'h0e
`define NO_RESP_PRESET_PROX_B 8'h0e
`define NO_RESP_PRESET_THIRD 8'h0e
`define NO_RESP_PRESET_PEER 8'h0e

`endif

// *** rtl/rx_ctrl.sv ***
// Receive control: protocol decode, collision position, blanking and no-response timers, signal level
`timescale 1ns/1ps
`default_nettype none
`include "rx_ctrl_regs.svh"

module rx_ctrl (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire rx_ctrl_pkg::reg_req_t i_reg,
   input wire logic i_cmd_valid,
   input wire logic [7:0] i_cmd_code,
   input wire logic i_tx_active,
   input wire logic i_slot_start,
   input wire logic i_rx_sof,
   input wire logic i_rx_active,
   input wire logic i_rx_frame_start,
   input wire logic i_rx_bit,
   input wire logic i_rx_collision,
   input wire rx_ctrl_pkg::rssi_levels_t i_rssi,
   input wire logic i_osc_stable,
   output logic [7:0] o_reg_rdata,
   output logic o_reg_rvalid,
   output rx_ctrl_pkg::mode_t o_mode,
   output logic o_rx_enable,
   output logic o_decoder_reset,
   output logic o_collision_event,
   output logic o_no_response_event,
   output logic [5:0] o_irq_mask,
   output logic [7:0] o_chip_status_control
);
   import rx_ctrl_pkg::*;

   // ==========================================
   // Timing
   localparam int BLANK_UNIT_CYC =
      (`BLANK_UNIT_PS * `CLK_MHZ + `PS_PER_US - 1) / `PS_PER_US;
   localparam int NO_RESP_UNIT_CYC =
      (`NO_RESP_UNIT_PS * `CLK_MHZ + `PS_PER_US - 1) / `PS_PER_US;
   localparam logic [11:0] BLANK_UNIT_LAST = 12'(BLANK_UNIT_CYC - 1);
   localparam logic [11:0] NO_RESP_UNIT_LAST = 12'(NO_RESP_UNIT_CYC - 1);

   // ==========================================
   // Protocol decode
   function automatic mode_t decode_mode(input logic [7:0] code);
      mode_t m;
      m = '0;
      m.valid = 1'b1;
      m.protocol = PROT_NONE;
      if (!code[`PSEL_PEER_BIT]) begin
         m.op_mode = OP_READER;
         unique case (code[4:3])
            2'b00: begin
               m.protocol = PROT_VICINITY;
               m.dual_subcarrier = code[2];
               m.rate = {1'b0, code[1]};
               m.coding_256 = code[0];
            end
            2'b01: begin
               m.protocol = code[2] ? PROT_PROX_B : PROT_PROX_A;
               m.rate = code[1:0];
            end
            default: begin
               m.protocol = code[1] ? PROT_THIRD_PARTY : PROT_NONE;
               m.rate = {code[0], ~code[0]};
               m.valid = code[1];
            end
         endcase
      end else if (!code[`PSEL_CARD_BIT]) begin
         // peer mode, role, passive or active
         m.op_mode = OP_PEER;
         m.initiator = code[`PSEL_ROLE_BIT];
         m.active_comm = code[`PSEL_ACTIVE_BIT];
         // peer bit rate, 00 not applicable
         m.rate = code[1:0] - 2'h1;
         m.protocol = PROT_PROX_A;
         m.valid = (code[1:0] != 2'h0);
      end else begin
         m.op_mode = OP_CARD_EMU;
         m.protocol = code[0] ? PROT_PROX_B : PROT_PROX_A;
         m.valid = !code[1];
      end
      if (!m.valid) begin
         m.protocol = PROT_NONE;
      end
      return m;
   endfunction

   function automatic logic [7:0] blank_preset(input mode_t m);
      logic [7:0] v;
      v = `BLANK_PRESET_VICINITY;
      if (m.op_mode != OP_READER) begin
         v = `BLANK_PRESET_PEER;
      end else if (m.protocol == PROT_PROX_A) begin
         v = `BLANK_PRESET_PROX_A;
      end else if (m.protocol == PROT_PROX_B) begin
         v = `BLANK_PRESET_PROX_B;
      end else if (m.protocol == PROT_THIRD_PARTY) begin
         v = `BLANK_PRESET_THIRD;
      end
      return v;
   endfunction

   function automatic logic [7:0] no_resp_preset(input mode_t m);
      logic [7:0] v;
      v = `NO_RESP_PRESET_VICINITY;
      if (m.op_mode != OP_READER) begin
         v = `NO_RESP_PRESET_PEER;
      end else if (m.protocol == PROT_PROX_A) begin
         v = `NO_RESP_PRESET_PROX_A;
      end else if (m.protocol == PROT_PROX_B) begin
         v = `NO_RESP_PRESET_PROX_B;
      end else if (m.protocol == PROT_THIRD_PARTY) begin
         v = `NO_RESP_PRESET_THIRD;
      end
      return v;
   endfunction

   // ==========================================
   // Registers
   logic [7:0] protocol_select;
   logic [7:0] no_response_wait_time;
   logic [7:0] receive_blank_time;
   logic [9:0] collision_position;
   logic [7:0] signal_level;
   logic tx_active_d;
   logic rx_active_d;
   mode_t next_mode;
   logic psel_wr;

   assign psel_wr = i_reg.wr && (i_reg.addr == `REG_PROTOCOL_SELECT);
   assign next_mode = decode_mode(psel_wr ? i_reg.wdata : protocol_select);

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         protocol_select <= `RST_PROTOCOL_SELECT;
         o_chip_status_control <= `RST_CHIP_STATUS_CONTROL;
         o_irq_mask <= `RST_IRQ_MASK;
      end else if (i_reg.wr) begin
         unique case (i_reg.addr)
            `REG_PROTOCOL_SELECT: protocol_select <= i_reg.wdata;
            `REG_CHIP_STATUS_CONTROL: o_chip_status_control <= i_reg.wdata;
            `REG_COLLISION_HIGH_AND_IRQ_MASK: o_irq_mask <= i_reg.wdata[5:0];
            default: ;
         endcase
      end
   end

   // Presets win over a plain write because the protocol select write is tested first
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         receive_blank_time <= blank_preset(decode_mode(`RST_PROTOCOL_SELECT));
         no_response_wait_time <= no_resp_preset(decode_mode(`RST_PROTOCOL_SELECT));
      end else if (psel_wr) begin
         // reload blank time, reload no-response time
         receive_blank_time <= blank_preset(next_mode);
         no_response_wait_time <= no_resp_preset(next_mode);
      end else if (i_reg.wr && i_reg.addr == `REG_RECEIVE_BLANK_TIME) begin
         receive_blank_time <= i_reg.wdata;
      end else if (i_reg.wr && i_reg.addr == `REG_NO_RESPONSE_WAIT_TIME) begin
         no_response_wait_time <= i_reg.wdata;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_mode <= decode_mode(`RST_PROTOCOL_SELECT);
      end else begin
         o_mode <= next_mode;
      end
   end

   // Read port: one cycle after the strobe
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_reg_rdata <= 8'h00;
         o_reg_rvalid <= 1'b0;
      end else begin
         o_reg_rvalid <= i_reg.rd;
         if (i_reg.rd) begin
            unique case (i_reg.addr)
               `REG_CHIP_STATUS_CONTROL: o_reg_rdata <= o_chip_status_control;
               `REG_PROTOCOL_SELECT: o_reg_rdata <= protocol_select;
               `REG_NO_RESPONSE_WAIT_TIME: o_reg_rdata <= no_response_wait_time;
               `REG_RECEIVE_BLANK_TIME: o_reg_rdata <= receive_blank_time;
               // top position bits over the mask
               `REG_COLLISION_HIGH_AND_IRQ_MASK:
                  o_reg_rdata <= {collision_position[9:8], o_irq_mask};
               `REG_COLLISION_POSITION_LOW: o_reg_rdata <= collision_position[7:0];
               `REG_SIGNAL_LEVEL_OSC_STATUS: o_reg_rdata <= signal_level;
               default: o_reg_rdata <= 8'h00;
            endcase
         end
      end
   end

   // ==========================================
   // Collision position
   logic [9:0] bit_count;
   logic coll_enable;

   assign coll_enable = o_mode.valid && o_mode.protocol == PROT_PROX_A;

   // count from zero after the start bit
   always_ff @(posedge i_clk) begin
      if (i_sys_rst || i_rx_frame_start) begin
         bit_count <= 10'h000;
      end else if (i_rx_bit) begin
         bit_count <= bit_count + 10'h001;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         collision_position <= 10'h000;
         o_collision_event <= 1'b0;
      end else begin
         o_collision_event <= i_rx_collision && i_rx_bit && coll_enable;
         if (i_rx_collision && i_rx_bit && coll_enable) begin
            collision_position <= bit_count;
         end
      end
   end

   // ==========================================
   // Receive blanking after transmit
   logic [11:0] blank_pre;
   logic [7:0] blank_left;

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         tx_active_d <= 1'b0;
         rx_active_d <= 1'b0;
      end else begin
         tx_active_d <= i_tx_active;
         rx_active_d <= i_rx_active;
      end
   end

   // units of 9.44 us after transmit end
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         blank_left <= 8'h00;
         blank_pre <= 12'h000;
      end else if (tx_active_d && !i_tx_active) begin
         blank_left <= receive_blank_time;
         blank_pre <= 12'h000;
      end else if (blank_left != 8'h00) begin
         if (blank_pre == BLANK_UNIT_LAST) begin
            blank_pre <= 12'h000;
            blank_left <= blank_left - 8'h01;
         end else begin
            blank_pre <= blank_pre + 12'h001;
         end
      end
   end

   // decoders idle on an invalid code
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_decoder_reset <= 1'b1;
         o_rx_enable <= 1'b0;
      end else begin
         o_rx_enable <= next_mode.valid;
         o_decoder_reset <= !next_mode.valid || i_tx_active
            || (tx_active_d && !i_tx_active && receive_blank_time != 8'h00)
            || (blank_left > 8'h01)
            || (blank_left == 8'h01 && blank_pre != BLANK_UNIT_LAST);
      end
   end

   // ==========================================
   // No-response slot timer
   logic [11:0] nr_pre;
   logic [7:0] nr_left;
   logic nr_armed;

   // units of 37.76 us from slot start
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         nr_armed <= 1'b0;
         nr_left <= 8'h00;
         nr_pre <= 12'h000;
         o_no_response_event <= 1'b0;
      end else begin
         o_no_response_event <= 1'b0;
         if (i_slot_start) begin
            nr_armed <= (no_response_wait_time != 8'h00) && o_mode.valid;
            nr_left <= no_response_wait_time;
            nr_pre <= 12'h000;
         end else if (i_rx_sof) begin
            nr_armed <= 1'b0;
         end else if (nr_armed) begin
            if (nr_pre == NO_RESP_UNIT_LAST) begin
               nr_pre <= 12'h000;
               nr_left <= nr_left - 8'h01;
               if (nr_left == 8'h01) begin
                  nr_armed <= 1'b0;
                  o_no_response_event <= 1'b1;
               end
            end else begin
               nr_pre <= nr_pre + 12'h001;
            end
         end
      end
   end

   // ==========================================
   // Signal level
   logic [2:0] peak_main;
   logic [2:0] peak_aux;
   logic use_ext;
   logic tx_on;

   assign use_ext = o_chip_status_control[`CSC_RSSI_EXT_BIT];
   assign tx_on = o_chip_status_control[`CSC_TX_ON_BIT];

   // clear on transmit start, peak hold while receiving
   always_ff @(posedge i_clk) begin
      if (i_sys_rst || (i_tx_active && !tx_active_d)) begin
         peak_main <= 3'h0;
         peak_aux <= 3'h0;
      end else if (i_rx_active) begin
         if (i_rssi.main > peak_main) begin
            peak_main <= i_rssi.main;
         end
         if (i_rssi.aux > peak_aux) begin
            peak_aux <= i_rssi.aux;
         end
      end
   end

   // both paths in one register, side by side
   // source select, capture on command with carrier on or external source selected
   always_ff @(posedge i_clk) begin
      if (i_sys_rst || (i_tx_active && !tx_active_d)) begin
         signal_level <= 8'h00;
      end else if (i_cmd_valid && i_cmd_code == `CMD_RSSI_MEASURE && (tx_on || use_ext)) begin
         // external level sits in the main field when chosen
         // Command samples the live path levels, not the last packet's peaks
         signal_level <= use_ext ? {1'b0, i_osc_stable, 3'h0, i_rssi.ext}
                                 : {1'b0, i_osc_stable, i_rssi.aux, i_rssi.main};
      end else if (rx_active_d && !i_rx_active && !use_ext) begin
         // Packet end publishes the held peaks unless the external source is selected
         signal_level <= {1'b0, i_osc_stable, peak_aux, peak_main};
      end else begin
         signal_level[`SLS_OSC_BIT] <= i_osc_stable;
      end
   end

endmodule

`default_nettype wire
